// ===== shared/omvc_defines.vh
// register map, field positions, reset values and timing constants for the output mixer block
`ifndef OMVC_DEFINES_VH
`define OMVC_DEFINES_VH

// register indices (byte address is four times the index)
`define OMVC_IDX_POWER_ONE 7'h01
`define OMVC_IDX_OUT_POWER 7'h03
`define OMVC_IDX_ADD_CTRL 7'h07
`define OMVC_IDX_SPK_MIX 7'h32
`define OMVC_IDX_SPK_VOL 7'h36
`define OMVC_IDX_MONO_MIX 7'h38
`define OMVC_IDX_ZC_CTRL 7'h40

// field positions
`define OMVC_BIT_BIAS 3
`define OMVC_BIT_BUF 2
`define OMVC_BIT_MONO_EN 7
`define OMVC_BIT_SPKN_EN 6
`define OMVC_BIT_SPKP_EN 5
`define OMVC_BIT_MONOMIX_EN 3
`define OMVC_BIT_SPKMIX_EN 2
`define OMVC_BIT_SLOW 0
`define OMVC_BIT_AUX_SPK 5
`define OMVC_BIT_BYP_SPK 1
`define OMVC_BIT_DAC_SPK 0
`define OMVC_BIT_SPK_ATT 8
`define OMVC_BIT_SPK_ZC 7
`define OMVC_BIT_SPK_MUTE 6
`define OMVC_BIT_MONO_ATT 7
`define OMVC_BIT_MONO_MUTE 6
`define OMVC_BIT_AUX_MONO 2
`define OMVC_BIT_BYP_MONO 1
`define OMVC_BIT_DAC_MONO 0
`define OMVC_BIT_ZC_RATE 0

// writable bit masks per register
`define OMVC_MASK_POWER_ONE 9'h00C
`define OMVC_MASK_OUT_POWER 9'h0EC
`define OMVC_MASK_ADD_CTRL 9'h001
`define OMVC_MASK_SPK_MIX 9'h023
`define OMVC_MASK_SPK_VOL 9'h1FF
`define OMVC_MASK_MONO_MIX 9'h0C7
`define OMVC_MASK_ZC_CTRL 9'h001

// reset values
`define OMVC_RST_ZERO 9'h000
`define OMVC_RST_SPK_VOL 9'h079
`define OMVC_GAIN_0DB 6'h39

// sign-change detection width of the speaker signal sample
`define OMVC_SIG_W 16

// timing: slow tick period 2^21 master clocks, timeout rates in Hz
`define OMVC_CLK_HZ 25000000
`define OMVC_TO_SLOW_HZ 31
`define OMVC_TO_FAST_HZ 47
`define OMVC_CNT_W 20

`endif

// ===== src/omvc_sync3.v
// three-flop synchroniser with agreement-based change acceptance
`timescale 1ns/1ns
module omvc_sync3 (
    clk,
    rst_b,
    async_in,
    sync_out
);
    input wire clk;
    input wire rst_b;
    input wire async_in;
    output reg sync_out;

    reg s1_q; // first stage, read only by second
    reg s2_q; // second stage
    reg s3_q; // third stage

    // shift chain; output follows once stages two and three agree
    always @(posedge clk) begin
        if (!rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                sync_out <= s3_q;
            end
        end
    end
endmodule // omvc_sync3

// ===== src/omvc_zc_timer.v
// zero-cross timeout counter, restarted on every gain write
`timescale 1ns/1ns
`include "omvc_defines.vh"
module omvc_zc_timer (
    clk,
    rst_b,
    enable,
    restart,
    limit,
    expired
);
    input wire clk;
    input wire rst_b;
    input wire enable;
    input wire restart;
    input wire [`OMVC_CNT_W-1:0] limit;
    output wire expired;

    reg [`OMVC_CNT_W-1:0] cnt_q; // cycles since restart

    assign expired = enable && (cnt_q >= limit);

    // counts only while the slow clock is on; holds otherwise
    always @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= {`OMVC_CNT_W{1'b0}};
        end else if (restart) begin
            cnt_q <= {`OMVC_CNT_W{1'b0}};
        end else if (enable && !expired) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule // omvc_zc_timer

// ===== src/omvc_output_mixer.v
// register bank and gain update control for the speaker and mono output paths
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
`include "omvc_defines.vh"
// Behaviour
// - speaker mixer selects aux, bypass, dac
// - speaker bypass attenuation bit eight
// - zero-cross bit defers speaker gain change
// - speaker mute resets on, holds mid level
// - six-bit gain code, 1dB steps, 0dB reset
// - negative speaker output is inverted positive
// - timeout applies pending gain with slow clock
// - timeout rate 31Hz or 47Hz
// - additional control bit zero enables slow clock
// - mono bypass attenuation bit seven
// - mono mute drives mid-rail reference
// - mono mixer selects aux, bypass, dac
// - output power enables, all reset off
// - bias and mid buffer enables
module omvc_output_mixer #(
    parameter TICK_PERIOD = 2097152
) (
    clk,
    rst_b,
    avs_address,
    avs_read,
    avs_write,
    avs_writedata,
    avs_byteenable,
    avs_readdata,
    avs_waitrequest,
    avs_response,
    speaker_signal,
    jack_insert,
    aux_to_speaker_sel,
    bypass_to_speaker_sel,
    dac_to_speaker_sel,
    speaker_bypass_atten,
    speaker_gain,
    speaker_out_pos,
    speaker_out_neg,
    output_mid_level,
    mono_bypass_atten,
    mono_out_mute,
    aux_to_mono_sel,
    bypass_to_mono_sel,
    dac_to_mono_sel,
    mono_output_pin,
    amp_bias_enable,
    mid_buffer_enable,
    mono_out_enable,
    speaker_neg_enable,
    speaker_pos_enable,
    mono_mixer_enable,
    speaker_mixer_enable,
    slow_tick_enable,
    slow_tick,
    jack_debounced
);
    input wire clk;
    input wire rst_b;
    input wire [8:0] avs_address; // byte address
    input wire avs_read;
    input wire avs_write;
    input wire [31:0] avs_writedata;
    input wire [3:0] avs_byteenable;
    output reg [31:0] avs_readdata;
    output wire avs_waitrequest;
    output reg [1:0] avs_response;
    input wire [`OMVC_SIG_W-1:0] speaker_signal; // signed sample of mixer output
    input wire jack_insert; // pin, asynchronous
    output wire aux_to_speaker_sel;
    output wire bypass_to_speaker_sel;
    output wire dac_to_speaker_sel;
    output wire speaker_bypass_atten;
    output reg [5:0] speaker_gain; // gain in effect
    output reg [`OMVC_SIG_W-1:0] speaker_out_pos;
    output reg [`OMVC_SIG_W-1:0] speaker_out_neg;
    output wire output_mid_level; // high while speaker held at mid level
    output wire mono_bypass_atten;
    output wire mono_out_mute; // high while mono drives mid reference
    output wire aux_to_mono_sel;
    output wire bypass_to_mono_sel;
    output wire dac_to_mono_sel;
    output reg [`OMVC_SIG_W-1:0] mono_output_pin;
    output wire amp_bias_enable;
    output wire mid_buffer_enable;
    output wire mono_out_enable;
    output wire speaker_neg_enable;
    output wire speaker_pos_enable;
    output wire mono_mixer_enable;
    output wire speaker_mixer_enable;
    output wire slow_tick_enable;
    output reg slow_tick; // one-cycle pulse every tick period
    output wire jack_debounced;

    // timeout limits in master clocks, derived from rate
    localparam [31:0] TO_SLOW_FULL = `OMVC_CLK_HZ / `OMVC_TO_SLOW_HZ; // full-width quotient
    localparam [31:0] TO_FAST_FULL = `OMVC_CLK_HZ / `OMVC_TO_FAST_HZ; // full-width quotient
    localparam [31:0] TICK_LAST_FULL = TICK_PERIOD - 1; // full-width last divider count
    localparam [`OMVC_CNT_W-1:0] TO_SLOW_CYC = TO_SLOW_FULL[`OMVC_CNT_W-1:0];
    localparam [`OMVC_CNT_W-1:0] TO_FAST_CYC = TO_FAST_FULL[`OMVC_CNT_W-1:0];
    localparam [21:0] TICK_LAST = TICK_LAST_FULL[21:0];

    reg [8:0] pow1_q; // power control one
    reg [8:0] opow_q; // output power control
    reg [8:0] add_q; // additional control
    reg [8:0] smix_q; // speaker mixer select
    reg [8:0] svol_q; // speaker volume control, pending gain
    reg [8:0] mmix_q; // mono mixer control
    reg [8:0] zc_q; // zero-cross timeout rate select
    reg pend_q; // gain waiting for zero crossing
    reg sign_q; // previous signal sign
    reg [21:0] tick_q; // slow tick divider
    reg jack_q; // debounced jack level
    reg [1:0] jack_cnt_q; // debounce tick count
    wire jack_sync; // synchronised jack pin
    wire [6:0] idx; // register index
    wire wr_en; // write accepted
    wire [8:0] wdat; // write data limited to lanes
    wire sign_chg; // zero crossing seen
    wire to_exp; // timeout expired
    wire vol_wr; // write to volume register
    reg rd_done_q; // read data registered, answer stands this cycle

    // reads wait one cycle so registered data stands while waitrequest is low
    assign avs_waitrequest = avs_read && !rd_done_q;
    assign idx = avs_address[8:2];
    assign wr_en = avs_write && !avs_read;
    assign wdat = {avs_byteenable[1] ? avs_writedata[8] : 1'b0,
                   avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};
    assign vol_wr = wr_en && (idx == `OMVC_IDX_SPK_VOL) && avs_byteenable[0];

    // field decode
    assign aux_to_speaker_sel = smix_q[`OMVC_BIT_AUX_SPK];
    assign bypass_to_speaker_sel = smix_q[`OMVC_BIT_BYP_SPK];
    assign dac_to_speaker_sel = smix_q[`OMVC_BIT_DAC_SPK];
    assign speaker_bypass_atten = svol_q[`OMVC_BIT_SPK_ATT];
    assign output_mid_level = svol_q[`OMVC_BIT_SPK_MUTE];
    assign mono_bypass_atten = mmix_q[`OMVC_BIT_MONO_ATT];
    assign mono_out_mute = mmix_q[`OMVC_BIT_MONO_MUTE];
    assign aux_to_mono_sel = mmix_q[`OMVC_BIT_AUX_MONO];
    assign bypass_to_mono_sel = mmix_q[`OMVC_BIT_BYP_MONO];
    assign dac_to_mono_sel = mmix_q[`OMVC_BIT_DAC_MONO];
    assign amp_bias_enable = pow1_q[`OMVC_BIT_BIAS];
    assign mid_buffer_enable = pow1_q[`OMVC_BIT_BUF];
    assign mono_out_enable = opow_q[`OMVC_BIT_MONO_EN];
    assign speaker_neg_enable = opow_q[`OMVC_BIT_SPKN_EN];
    assign speaker_pos_enable = opow_q[`OMVC_BIT_SPKP_EN];
    assign mono_mixer_enable = opow_q[`OMVC_BIT_MONOMIX_EN];
    assign speaker_mixer_enable = opow_q[`OMVC_BIT_SPKMIX_EN];
    assign slow_tick_enable = add_q[`OMVC_BIT_SLOW];
    assign jack_debounced = jack_q;

    // register writes; masks keep undocumented bits at zero
    always @(posedge clk) begin
        if (!rst_b) begin
            pow1_q <= `OMVC_RST_ZERO;
            opow_q <= `OMVC_RST_ZERO;
            add_q <= `OMVC_RST_ZERO;
            smix_q <= `OMVC_RST_ZERO;
            svol_q <= `OMVC_RST_SPK_VOL;
            mmix_q <= `OMVC_RST_ZERO;
            zc_q <= `OMVC_RST_ZERO;
        end else if (wr_en) begin
            case (idx)
                `OMVC_IDX_POWER_ONE: pow1_q <= wdat & `OMVC_MASK_POWER_ONE;
                `OMVC_IDX_OUT_POWER: opow_q <= wdat & `OMVC_MASK_OUT_POWER;
                `OMVC_IDX_ADD_CTRL: add_q <= wdat & `OMVC_MASK_ADD_CTRL;
                `OMVC_IDX_SPK_MIX: smix_q <= wdat & `OMVC_MASK_SPK_MIX;
                `OMVC_IDX_SPK_VOL: svol_q <= wdat & `OMVC_MASK_SPK_VOL;
                `OMVC_IDX_MONO_MIX: mmix_q <= wdat & `OMVC_MASK_MONO_MIX;
                `OMVC_IDX_ZC_CTRL: zc_q <= wdat & `OMVC_MASK_ZC_CTRL;
                default: begin
                end
            endcase
        end
    end

    // read mux; unmapped index answers zero with a slave error
    always @(posedge clk) begin
        if (!rst_b) begin
            avs_readdata <= 32'h00000000;
            avs_response <= 2'h0;
        end else begin
            avs_response <= 2'h0;
            avs_readdata <= 32'h00000000;
            if (avs_read || avs_write) begin
                case (idx)
                    `OMVC_IDX_POWER_ONE: avs_readdata <= {23'h000000, pow1_q};
                    `OMVC_IDX_OUT_POWER: avs_readdata <= {23'h000000, opow_q};
                    `OMVC_IDX_ADD_CTRL: avs_readdata <= {23'h000000, add_q};
                    `OMVC_IDX_SPK_MIX: avs_readdata <= {23'h000000, smix_q};
                    `OMVC_IDX_SPK_VOL: avs_readdata <= {23'h000000, svol_q};
                    `OMVC_IDX_MONO_MIX: avs_readdata <= {23'h000000, mmix_q};
                    `OMVC_IDX_ZC_CTRL: avs_readdata <= {22'h000000, pend_q, zc_q};
                    default: avs_response <= 2'h2;
                endcase
            end
        end
    end

    // read handshake: one wait state, then the answer for one cycle
    always @(posedge clk) begin
        if (!rst_b) begin
            rd_done_q <= 1'b0;
        end else begin
            rd_done_q <= avs_read && !rd_done_q;
        end
    end

    // slow tick divider, runs only while enabled
    always @(posedge clk) begin
        if (!rst_b) begin
            tick_q <= 22'h000000;
            slow_tick <= 1'b0;
        end else if (slow_tick_enable) begin
            slow_tick <= (tick_q == TICK_LAST);
            tick_q <= (tick_q == TICK_LAST) ? 22'h000000 : tick_q + 22'h000001;
        end else begin
            tick_q <= 22'h000000;
            slow_tick <= 1'b0;
        end
    end

    // jack pin synchronised, then debounced over two slow ticks
    omvc_sync3 u_jack_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in(jack_insert),
        .sync_out(jack_sync)
    );

    // debounce: level must hold across consecutive slow ticks
    always @(posedge clk) begin
        if (!rst_b) begin
            jack_q <= 1'b0;
            jack_cnt_q <= 2'h0;
        end else if (jack_sync == jack_q) begin
            jack_cnt_q <= 2'h0;
        end else if (slow_tick) begin
            if (jack_cnt_q == 2'h1) begin
                jack_q <= jack_sync;
                jack_cnt_q <= 2'h0;
            end else begin
                jack_cnt_q <= jack_cnt_q + 2'h1;
            end
        end
    end

    // zero-cross timeout; rate picks 31Hz or 47Hz
    omvc_zc_timer u_zc_timer (
        .clk(clk),
        .rst_b(rst_b),
        .enable(slow_tick_enable),
        .restart(vol_wr),
        .limit(zc_q[`OMVC_BIT_ZC_RATE] ? TO_FAST_CYC : TO_SLOW_CYC),
        .expired(to_exp)
    );

    assign sign_chg = speaker_signal[`OMVC_SIG_W-1] != sign_q;

    // gain update: immediate, or on sign change or timeout when gated
    always @(posedge clk) begin
        if (!rst_b) begin
            speaker_gain <= `OMVC_GAIN_0DB;
            pend_q <= 1'b0;
            sign_q <= 1'b0;
        end else begin
            sign_q <= speaker_signal[`OMVC_SIG_W-1];
            if (vol_wr) begin
                if (wdat[`OMVC_BIT_SPK_ZC]) begin
                    pend_q <= 1'b1;
                end else begin
                    speaker_gain <= wdat[5:0];
                    pend_q <= 1'b0;
                end
            end else if (pend_q && (sign_chg || to_exp)) begin
                speaker_gain <= svol_q[5:0];
                pend_q <= 1'b0;
            end
        end
    end

    // output drive: mute holds mid level (zero), negative is inverse
    always @(posedge clk) begin
        if (!rst_b) begin
            speaker_out_pos <= {`OMVC_SIG_W{1'b0}};
            speaker_out_neg <= {`OMVC_SIG_W{1'b0}};
            mono_output_pin <= {`OMVC_SIG_W{1'b0}};
        end else begin
            if (output_mid_level) begin
                speaker_out_pos <= {`OMVC_SIG_W{1'b0}};
                speaker_out_neg <= {`OMVC_SIG_W{1'b0}};
            end else begin
                speaker_out_pos <= speaker_signal;
                speaker_out_neg <= ~speaker_signal + 1'b1;
            end
            mono_output_pin <= mono_out_mute ? {`OMVC_SIG_W{1'b0}} : speaker_signal;
        end
    end
endmodule // omvc_output_mixer

// ===== verif/omvc_output_mixer_props.sv
// concurrent checks on the ports of the output mixer register bank
`timescale 1ns/1ns
`include "omvc_defines.vh"
module omvc_output_mixer_props #(
    parameter TICK_PERIOD = 2097152
) (
    input wire clk,
    input wire rst_b,
    input wire [8:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire [1:0] avs_response,
    input wire avs_waitrequest,
    input wire [`OMVC_SIG_W-1:0] speaker_signal,
    input wire [5:0] speaker_gain,
    input wire [`OMVC_SIG_W-1:0] speaker_out_pos,
    input wire [`OMVC_SIG_W-1:0] speaker_out_neg,
    input wire output_mid_level,
    input wire mono_out_mute,
    input wire [`OMVC_SIG_W-1:0] mono_output_pin,
    input wire slow_tick_enable,
    input wire slow_tick
);
    reg sign_q; // sign of the previous sample
    reg map_q; // last request hit a mapped register
    reg [5:0] vol_q; // gain field of the last volume write
    wire flip = speaker_signal[`OMVC_SIG_W-1] ^ sign_q; // sign changed this cycle
    wire vol_wr = avs_write && avs_address == 9'h0D8 && avs_byteenable[0]; // volume write

    // history kept for the properties
    always @(posedge clk) begin
        sign_q <= speaker_signal[`OMVC_SIG_W-1];
        map_q <= avs_address inside {9'h004, 9'h00C, 9'h01C, 9'h0C8, 9'h0D8, 9'h0E0, 9'h100};
        if (vol_wr) begin
            vol_q <= avs_writedata[5:0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // deferred gain write while the sign holds
    sequence zc_write;
        vol_wr && avs_writedata[7] && !slow_tick_enable && !flip;
    endsequence
    // quiet wait, then a sign change
    sequence zc_wait;
        zc_write ##1 (!avs_write && !flip) [*3] ##1 flip;
    endsequence

    rst_value_a: assert property ($rose(rst_b) |-> speaker_gain == 6'h39 && output_mid_level)
        else $error("gain or mute wrong after reset");
    gain_now_a: assert property (vol_wr && !avs_writedata[7] |=> speaker_gain == vol_q)
        else $error("immediate gain not applied");
    mute_bit_a: assert property (vol_wr |=> output_mid_level == $past(avs_writedata[6]))
        else $error("speaker mute does not follow its bit");
    zc_hold_a: assert property (zc_write ##1 (!flip && !vol_wr) |=> $stable(speaker_gain))
        else $error("deferred gain changed without a crossing");
    zc_apply_a: assert property (zc_wait |-> ##[1:2] speaker_gain == vol_q)
        else $error("pending gain not applied at crossing");
    neg_inv_a: assert property (speaker_out_neg == 16'h0000 - speaker_out_pos)
        else $error("negative output not inverted");
    spk_mute_a: assert property (output_mid_level [*2] |-> speaker_out_pos == 16'h0000)
        else $error("muted speaker not at mid level");
    mono_mute_a: assert property (mono_out_mute [*2] |-> mono_output_pin == 16'h0000)
        else $error("muted mono not at mid reference");
    resp_code_a: assert property (avs_read |=> avs_response == (map_q ? 2'h0 : 2'h2))
        else $error("read response code wrong");
    rd_clean_a: assert property (avs_read && avs_address == 9'h01C |=> avs_readdata[31:1] == 0)
        else $error("unused bits read nonzero");
    tick_gap_a: assert property (slow_tick |=> !slow_tick [*8])
        else $error("slow ticks too close");
    tick_off_a: assert property (!slow_tick_enable [*3] |-> !slow_tick)
        else $error("slow tick while disabled");
    rd_wait_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read waits more than one cycle");
    wr_wait_a: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
endmodule // omvc_output_mixer_props

bind omvc_output_mixer omvc_output_mixer_props #(.TICK_PERIOD(TICK_PERIOD)) u_props (.*);

// ===== verif/tb_top.sv
// self-checking bench for the output mixer register bank
`timescale 1ns/1ns
module tb_top;
    // six register addresses, reset values, writable masks with bit seven clear and two test patterns
    localparam bit [8:0] AD [0:5] = '{9'h004, 9'h00C, 9'h01C, 9'h0C8, 9'h0D8, 9'h0E0};
    localparam bit [8:0] RV [0:5] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h079, 9'h000};
    localparam bit [8:0] MK [0:5] = '{9'h00C, 9'h06C, 9'h001, 9'h023, 9'h17F, 9'h047};
    localparam bit [8:0] PA [0:5] = '{9'h008, 9'h0A4, 9'h000, 9'h021, 9'h13F, 9'h085};
    localparam bit [8:0] PB [0:5] = '{9'h004, 9'h048, 9'h001, 9'h002, 9'h040, 9'h042};
    reg clk = 1'b0; // 25 MHz master clock
    reg rst_b = 1'b0; // held low at start
    reg [8:0] avs_address = 9'h000;
    reg avs_read = 1'b0;
    reg avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h00000000;
    reg [15:0] speaker_signal = 16'h0100; // positive sample
    reg jack_pin = 1'b0; // jack detect pin level
    wire jack_deb; // debounced jack level
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [1:0] avs_response;
    wire [5:0] speaker_gain;
    wire [15:0] spk_pos;
    wire [15:0] spk_neg;
    wire [15:0] mono_pin;
    wire slow_tick;
    wire [17:0] flds; // field outputs, bias enable at the top
    reg [31:0] rdat; // last read data
    reg [1:0] rresp; // last response code
    integer err_total = 0;
    integer total_checks = 0;
    integer i;
    integer n;

    omvc_output_mixer #(.TICK_PERIOD(16)) dut (
        .clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .speaker_signal(speaker_signal), .jack_insert(jack_pin),
        .amp_bias_enable(flds[17]), .mid_buffer_enable(flds[16]), .mono_out_enable(flds[15]),
        .speaker_neg_enable(flds[14]), .speaker_pos_enable(flds[13]),
        .mono_mixer_enable(flds[12]), .speaker_mixer_enable(flds[11]),
        .slow_tick_enable(flds[10]), .aux_to_speaker_sel(flds[9]),
        .bypass_to_speaker_sel(flds[8]), .dac_to_speaker_sel(flds[7]),
        .speaker_bypass_atten(flds[6]), .output_mid_level(flds[5]), .mono_bypass_atten(flds[4]),
        .mono_out_mute(flds[3]), .aux_to_mono_sel(flds[2]), .bypass_to_mono_sel(flds[1]),
        .dac_to_mono_sel(flds[0]), .speaker_gain(speaker_gain), .speaker_out_pos(spk_pos),
        .speaker_out_neg(spk_neg), .mono_output_pin(mono_pin), .slow_tick(slow_tick),
        .jack_debounced(jack_deb)
    );

    // free-running clock, 40 ns period
    initial begin
        forever #20 clk = ~clk;
    end

    // counts and verdict, then stop
    task finish_test;
        begin
            $display("checks %0d errors %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // one comparison, reported on mismatch
    task automatic chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                $display("ERROR %s expected %h seen %h", nm, e, g);
                err_total = err_total + 1;
            end
        end
    endtask

    // one bus cycle held until waitrequest is sampled low; data taken at that edge
    task automatic bus(input bit w, input [8:0] a, input [31:0] d);
        begin
            n = 0;
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= w;
            avs_read <= !w;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0) begin
                n = n + 1;
                if (n > 50) begin
                    err_total = err_total + 1;
                    finish_test;
                end
                @(posedge clk);
            end
            rdat = avs_readdata;
            rresp = avs_response;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge clk);
        end
    endtask

    // read and compare data and an okay response
    task automatic rd(input [8:0] a, input [31:0] e);
        begin
            bus(1'b0, a, 32'h0);
            chk("readdata", e, rdat);
            chk("response", 32'h0, {30'h0, rresp});
        end
    endtask

    // reset values, then writable-bit masks less bit seven of every register but zero-cross control
    task automatic scen_regs;
        begin
            for (i = 0; i < 6; i = i + 1) rd(AD[i], RV[i]);
            chk("fields", 32'h00020, flds);
            chk("gain", 32'h39, speaker_gain);
            for (i = 0; i < 6; i = i + 1) begin
                bus(1'b1, AD[i], 32'hFFFFFF7F);
                rd(AD[i], MK[i]);
            end
        end
    endtask

    // complementary patterns drive every field output both ways
    task automatic scen_fields(input bit p);
        begin
            for (i = 0; i < 6; i = i + 1) bus(1'b1, AD[i], p ? PB[i] : PA[i]);
            for (i = 0; i < 6; i = i + 1) rd(AD[i], p ? PB[i] : PA[i]);
            chk("fields", p ? 32'h1552A : 32'h2AAD5, flds);
            speaker_signal <= 16'h1234;
            repeat (3) @(posedge clk);
            chk("inverted", p ? 32'h0 : 32'h0000EDCC, {16'h0, spk_neg});
            chk("gain", p ? 32'h00 : 32'h3F, speaker_gain);
            chk("outputs", p ? 32'h0 : 32'h12341234, {spk_pos, mono_pin});
        end
    endtask

    // unmapped place refuses with an error response
    task automatic scen_bad;
        begin
            bus(1'b1, 9'h010, 32'h000001FF);
            bus(1'b0, 9'h010, 32'h0);
            chk("unmapped response", 32'h2, {30'h0, rresp});
            chk("unmapped data", 32'h0, rdat);
            bus(1'b1, 9'h100, 32'h000001FF);
            rd(9'h100, 32'h001);
        end
    endtask

    // count slow ticks over a whole number of periods
    task automatic count_ticks(input [31:0] e);
        begin
            repeat (4) @(posedge clk);
            n = 0;
            repeat (64) begin
                @(posedge clk);
                if (slow_tick === 1'b1) n = n + 1;
            end
            chk("ticks", e, n);
        end
    endtask

    // deferred gain waits for a sign change, plain write applies at once
    task automatic scen_zc;
        begin
            bus(1'b1, 9'h0D8, 32'h000000A0);
            repeat (2) @(posedge clk);
            chk("held gain", 32'h00, speaker_gain);
            speaker_signal <= 16'hFF00;
            repeat (3) @(posedge clk);
            chk("crossed gain", 32'h20, speaker_gain);
            bus(1'b1, 9'h0D8, 32'h00000011);
            chk("direct gain", 32'h11, speaker_gain);
            bus(1'b1, 9'h0D8, 32'h000000A5);
            rd(9'h100, 32'h201);
            chk("pending gain", 32'h11, speaker_gain);
            speaker_signal <= 16'h0100;
            repeat (3) @(posedge clk);
            chk("second crossing", 32'h25, speaker_gain);
            rd(9'h100, 32'h001);
        end
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        err_total = err_total + 1;
        finish_test;
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        scen_regs;
        scen_bad;
        scen_fields(1'b0);
        scen_fields(1'b1);
        jack_pin <= 1'b1;
        count_ticks(4);
        chk("jack", 32'h1, jack_deb);
        bus(1'b1, 9'h01C, 32'h0);
        count_ticks(0);
        scen_zc;
        finish_test;
    end
endmodule // tb_top
